// *** src/sbgp_defs.vh ***
// Purpose: constants for the scripted byte gpio port
// Assumes: one byte-wide port, index 0
// Notes:   opcode codes are local choices
`ifndef SBGP_DEFS_VH
`define SBGP_DEFS_VH
`define SBGP_OP_CFG_LINE 2'h0
`define SBGP_OP_CFG_PORT 2'h1
`define SBGP_OP_RD_LINE  2'h2
`define SBGP_OP_NOP      2'h3
`define SBGP_DIR_RESET   8'h00
`define SBGP_PORT_ONLY   3'h0
`define SBGP_RD_DEPTH    16
`define SBGP_RD_IDX_W    4
`endif

// *** src/sbgp_port.v ***
// Purpose: byte-wide gpio port executing script commands one per cycle
// Assumes: commands arrive in script order on cmd_valid_i
// Notes:   read results kept in a small array, fetched by read index
//
// Summary of operation
// - line config changes only the selected line
// - port bitmap: one is output, zero input
// - port config updates all eight lines together
// - line read samples only selected line
// - read result is zero low, one high
// - result stored at its read index position
`include "sbgp_defs.vh"

module sbgp_port #(
  parameter RD_DEPTH = `SBGP_RD_DEPTH,
  parameter IDX_W    = `SBGP_RD_IDX_W
) (
  input  wire             sys_clk_i,
  input  wire             rst_b_i,
  input  wire             clk_en_i,
  input  wire             script_start_i,
  input  wire             cmd_valid_i,
  input  wire [1:0]       cmd_op_i,
  input  wire [2:0]       cmd_port_i,
  input  wire [2:0]       cmd_line_i,
  input  wire             cmd_line_out_i,
  input  wire [7:0]       cmd_dir_map_i,
  input  wire [7:0]       line_out_i,
  input  wire [7:0]       line_in_i,
  input  wire [IDX_W-1:0] rd_idx_i,
  output wire             cmd_ready_o,
  output reg  [7:0]       line_o,
  output reg  [7:0]       line_oe_o,
  output reg              rd_data_o,
  output reg  [IDX_W-1:0] rd_count_o,
  output reg              cmd_err_o
);

  localparam [7:0]       LINE0_HOT = 8'h01;
  localparam [IDX_W-1:0] IDX_ONE   = {{(IDX_W-1){1'b0}}, 1'b1};

  // command decode, one command per cycle
  wire               take;
  wire               port_ok;
  wire               cmd_ok;
  wire               do_cfg_line;
  wire               do_cfg_port;
  wire               do_rd_line;
  wire               do_bad_port;
  wire [7:0]         line_sel;
  wire [7:0]         next_oe;
  wire               sample_bit;
  reg                op_cfg_line;
  reg                op_cfg_port;
  reg                op_rd_line;
  reg  [IDX_W-1:0]   next_rd_count;
  reg                next_err;
  reg                next_rd_data;
  reg  [7:0]         next_line;
  reg  [7:0]         pin_meta;
  reg  [7:0]         pin_sync;
  reg                rd_mem [0:RD_DEPTH-1];
  genvar             gl;
  genvar             ge;

  // no wait states: ready follows the enable, so script order is kept for free
  assign cmd_ready_o = clk_en_i;
  assign take        = cmd_valid_i & clk_en_i;
  assign port_ok     = (cmd_port_i == `SBGP_PORT_ONLY);
  // a script start wins over a command in the same cycle
  assign cmd_ok      = take & port_ok & ~script_start_i;
  assign do_bad_port = take & ~port_ok & ~script_start_i;
  assign do_cfg_line = cmd_ok & op_cfg_line;
  assign do_cfg_port = cmd_ok & op_cfg_port;
  assign do_rd_line  = cmd_ok & op_rd_line;
  assign line_sel    = LINE0_HOT << cmd_line_i;
  assign sample_bit  = pin_sync[cmd_line_i];

  // nop and any spare code decode to nothing
  always @* begin
    op_cfg_line = 1'b0;
    op_cfg_port = 1'b0;
    op_rd_line  = 1'b0;
    case (cmd_op_i)
      `SBGP_OP_CFG_LINE: begin
        op_cfg_line = 1'b1;
      end
      `SBGP_OP_CFG_PORT: begin
        op_cfg_port = 1'b1;
      end
      `SBGP_OP_RD_LINE: begin
        op_rd_line = 1'b1;
      end
      default: begin
        op_cfg_line = 1'b0;
      end
    endcase
  end

  // pins are asynchronous: two flops before anything reads them
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else if (clk_en_i) begin
      pin_meta <= line_in_i;
      pin_sync <= pin_meta;
    end
  end

  // only one opcode per cycle, so line and port updates never meet
  generate
    for (gl = 0; gl < 8; gl = gl + 1) begin : g_line
      reg next_dir;
      always @* begin
        next_dir = line_oe_o[gl];
        if (do_cfg_port) begin
          next_dir = cmd_dir_map_i[gl];
        end else if (do_cfg_line && line_sel[gl]) begin
          next_dir = cmd_line_out_i;
        end else begin
          next_dir = line_oe_o[gl];
        end
      end
      assign next_oe[gl] = next_dir;
    end
  endgenerate

  // all eight directions load in the same edge
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_oe_o <= `SBGP_DIR_RESET;
    end else if (clk_en_i) begin
      line_oe_o <= next_oe;
    end
  end

  // output values pass through one cycle late, gated by direction at the pin
  always @* begin
    next_line = line_out_i;
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_o <= 8'h00;
    end else if (clk_en_i) begin
      line_o <= next_line;
    end
  end

  always @* begin
    next_rd_count = rd_count_o;
    if (script_start_i) begin
      next_rd_count = {IDX_W{1'b0}};
    end else if (do_rd_line) begin
      next_rd_count = rd_count_o + IDX_ONE;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_count_o <= {IDX_W{1'b0}};
    end else if (clk_en_i) begin
      rd_count_o <= next_rd_count;
    end
  end

  // sticky until the next script start
  always @* begin
    next_err = cmd_err_o;
    if (script_start_i) begin
      next_err = 1'b0;
    end else if (do_bad_port) begin
      next_err = 1'b1;
    end
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_err_o <= 1'b0;
    end else if (clk_en_i) begin
      cmd_err_o <= next_err;
    end
  end

  // read-back costs one cycle so the result leaves a flop
  always @* begin
    next_rd_data = rd_mem[rd_idx_i];
  end

  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 1'b0;
    end else if (clk_en_i) begin
      rd_data_o <= next_rd_data;
    end
  end

  // results live in flops; the index wraps silently past RD_DEPTH reads
  generate
    for (ge = 0; ge < RD_DEPTH; ge = ge + 1) begin : g_rd
      localparam [IDX_W-1:0] SLOT = ge;
      wire hit;
      assign hit = do_rd_line && (rd_count_o == SLOT);
      always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          rd_mem[ge] <= 1'b0;
        end else if (clk_en_i && hit) begin
          rd_mem[ge] <= sample_bit;
        end
      end
    end
  endgenerate

endmodule // sbgp_port

// *** verification/sbgp_checker.sv ***
// Purpose: concurrent checks on the port's own outputs
// Assumes: sees only the top module's ports
// Notes:   a low clock enable freezes every register
module sbgp_checker #(parameter IDX_W=4) (input wire sys_clk_i,rst_b_i,clk_en_i,
  script_start_i,cmd_valid_i,cmd_line_out_i,cmd_err_o,input wire [1:0] cmd_op_i,
  input wire [2:0] cmd_port_i,cmd_line_i,input wire [7:0] cmd_dir_map_i,line_oe_o,
  input wire [IDX_W-1:0] rd_count_o);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire g=cmd_valid_i&clk_en_i&!script_start_i;
  wire t=g&(cmd_port_i==3'h0);
  sequence rd_s; t&&cmd_op_i==2'h2; endsequence
  sequence bad_s; g&&cmd_port_i!=3'h0; endsequence
  sequence clr_s; clk_en_i&&script_start_i; endsequence
  map_all_a: assert property (t&&cmd_op_i==2'h1|=>line_oe_o==$past(cmd_dir_map_i))
    else $error("map");
  one_line_a: assert property (t&&cmd_op_i==2'h0|=>line_oe_o==(($past(line_oe_o)
    &~(8'h01<<$past(cmd_line_i)))|({7'h00,$past(cmd_line_out_i)}<<$past(cmd_line_i))))
    else $error("line");
  rd_cnt_a: assert property (rd_s|=>rd_count_o==$past(rd_count_o)+1'b1) else $error("cnt");
  rd_keep_a: assert property (rd_s|=>$stable(line_oe_o)) else $error("keep");
  bad_port_a: assert property (bad_s|=>cmd_err_o&&$stable(line_oe_o)) else $error("port");
  frozen_a: assert property (!clk_en_i|=>$stable(line_oe_o)&&$stable(rd_count_o))
    else $error("freeze");
  start_clr_a: assert property (clr_s|=>rd_count_o==0&&!cmd_err_o) else $error("clear");
endmodule // sbgp_checker
bind sbgp_port sbgp_checker #(.IDX_W(IDX_W)) i_chk(.sys_clk_i(sys_clk_i),.rst_b_i(rst_b_i),
  .clk_en_i(clk_en_i),.script_start_i(script_start_i),.cmd_valid_i(cmd_valid_i),
  .cmd_line_out_i(cmd_line_out_i),.cmd_err_o(cmd_err_o),.cmd_op_i(cmd_op_i),
  .cmd_port_i(cmd_port_i),.cmd_line_i(cmd_line_i),.cmd_dir_map_i(cmd_dir_map_i),
  .line_oe_o(line_oe_o),.rd_count_o(rd_count_o));

// *** verification/sbgp_pins.sv ***
// Purpose: pin side model
// Assumes: no pulls
// Notes: idle lines show bench level
module sbgp_pins(input wire [7:0] o_i,oe_i,ext_i,output wire [7:0] in_o);
  timeunit 1ns; timeprecision 1ns;
  assign in_o=(o_i&oe_i)|(ext_i&~oe_i);
endmodule // sbgp_pins

// *** verification/sbgp_port_tb_top.sv ***
// Purpose: random script test against a queue model
// Assumes: gaps let pins settle through the two sync flops
// Notes:   port index mostly zero; a nonzero one must raise the error flag
module sbgp_port_tb_top;
  timeunit 1ns; timeprecision 1ns;
  logic c=0,r=0,en=0,st=0,v=0,ls=0,rd,er,rdy; logic [1:0] op=0; logic [2:0] pt=0,ln=0;
  logic [7:0] dm=0,lo=0,ex=0,oe,lq,li; logic [3:0] ri=0,rc,n=0;
  int miscompares=0,checks_done=0,cyc=0; bit [31:0] x=32'h5DEBF7C3; bit [7:0] d=0,p=0;
  bit e=0; bit q[$];
  sbgp_port i_dut(.sys_clk_i(c),.rst_b_i(r),.clk_en_i(en),.script_start_i(st),
    .cmd_valid_i(v),.cmd_op_i(op),.cmd_port_i(pt),.cmd_line_i(ln),.cmd_line_out_i(ls),
    .cmd_dir_map_i(dm),.line_out_i(lo),.line_in_i(li),.rd_idx_i(ri),.cmd_ready_o(rdy),
    .line_o(lq),.line_oe_o(oe),.rd_data_o(rd),.rd_count_o(rc),.cmd_err_o(er));
  sbgp_pins i_pins(.o_i(lq),.oe_i(oe),.ext_i(ex),.in_o(li));
  initial forever #20 c=~c;
  always @(posedge c) if (++cyc>3000) begin miscompares++; complete_run; end
  function automatic bit [31:0] xs(bit [31:0] s);
    s^=s<<13; s^=s>>17; s^=s<<5; return s;
  endfunction
  task automatic chk(logic [7:0] s,w); checks_done++;
    if (s!==w) begin miscompares++; $display("CHECK FAILED %0t %h %h",$time,s,w); end endtask
  task complete_run; $display("checks %0d bad %0d",checks_done,miscompares);
    if (miscompares==0&&checks_done>0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish; endtask
  initial begin
    repeat (20) @(posedge c); r<=1; en<=1; x=xs(x); lo<=x[7:0]; ex<=x[15:8];
    while (q.size()<16) begin
      x=xs(x); @(posedge c); v<=1; en<=!(&x[23:21]); op<=x[1:0]; pt<={2'h0,&x[4:2]};
      ln<=x[10:8]; ls<=x[11]; dm<=x[19:12]; #1 chk(rdy,{7'h00,!(&x[23:21])});
      @(posedge c); v<=0; en<=1;
      if (!(&x[23:21])) begin
        if (&x[4:2]) e=1;
        else case (x[1:0]) 0: d[x[10:8]]=x[11]; 1: d=x[19:12];
          2: begin p=(d&lo)|(~d&ex); q.push_back(p[x[10:8]]); n++; end default: ; endcase
      end
      repeat (3) @(posedge c); #1 chk(oe,d);
      chk(rc,n);
      chk(er,e);
      chk(lq,lo);
    end
    chk(rc,0);
    $display("direction test done");
    foreach (q[i]) begin
      @(posedge c); ri<=i[3:0]; repeat (2) @(posedge c); #1 chk(rd,q[i]);
    end
    $display("read test done");
    @(posedge c); st<=1; @(posedge c); st<=0; #1 chk(rc,0);
    chk(er,0);
    $display("start test done"); complete_run;
  end
endmodule // sbgp_port_tb_top
